// file: watchdog_timer_timed_config.sv
// Watchdog timer with timed change sequence, mode control and expiry actions
//
// Functional notes
// - Counter advances on each cycle of the separate 128 kHz oscillator.
// - Reaching the selected time-out gives an interrupt or reset per mode.
// - Restart instruction returns the counter to zero; software issues it in time.
// - Interrupt-only mode raises an interrupt usable for wake-up or timing.
// - Combined mode: first expiry interrupts, a later expiry resets.
// - Always-on fuse forces permanent reset mode regardless of software.
// - With fuse, reset enable reads one, interrupt enable zero; writes ignored.
// - Clearing reset enable and new prescale accepted only within four cycles after opening.
// - Time-out selectable from about 16 ms to about 8 s.
// - After a watchdog reset the watchdog stays enabled.
// - Prescale code n selects 2048 shifted left by n cycles, codes above 9 reserved.
// - While the watchdog reset flag is set, reset enable is held at one.
// - Interrupt flag set on expiry in interrupt or combined mode, cleared by vector or by writing one.
// - Combined mode vector clears interrupt enable and flag together.
`timescale 1ns/10ps
module watchdog_timer_timed_config #(
   parameter int BASE_CYCLES = wdt_pkg::BASE_OSC_CYCLES
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       osc_tick_i,
   input  wire logic                       always_on_fuse_i,
   input  wire logic                       watchdog_reset_flag_i,
   input  wire logic                       restart_i,
   input  wire logic                       irq_vector_i,
   input  wire logic                       ctrl_wr_i,
   input  wire logic [wdt_pkg::CTRL_W-1:0] ctrl_wdata_i,
   output logic      [wdt_pkg::CTRL_W-1:0] ctrl_rdata_o,
   output logic                            timeout_irq_o,
   output logic                            wdt_reset_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   logic                       reset_enable_bit;
   logic                       timeout_irq_enable;
   logic                       timeout_irq_flag;
   logic [3:0]                 prescale_select;
   logic [wdt_pkg::WIN_W-1:0]  win_cnt;
   logic                       osc_q;

   logic                       next_reset_enable;
   logic                       next_irq_enable;
   logic                       next_irq_flag;
   logic [3:0]                 next_prescale;
   logic [wdt_pkg::WIN_W-1:0]  next_win_cnt;

   // ****************************************************************
   // Decoding
   // ****************************************************************
   wire                        wr_ce;
   wire                        wr_re;
   wire                        wr_ie;
   wire                        wr_flag;
   wire [3:0]                  wr_ps;
   wire                        change_enable_bit;
   wire                        open_wr;
   wire                        chg_wr;
   wire                        re_eff;
   wire                        ie_eff;
   wire                        tick;
   wire                        run;
   wire                        expire;
   wire                        vec_both;
   wire                        flag_set;
   wire                        flag_clr;
   wire                        reset_now;
   wire [wdt_pkg::CNT_W-1:0]   limit;
   wdt_pkg::mode_t             mode;

   assign wr_ce   = ctrl_wdata_i[wdt_pkg::CE_POS];
   assign wr_re   = ctrl_wdata_i[wdt_pkg::RE_POS];
   assign wr_ie   = ctrl_wdata_i[wdt_pkg::IRQ_EN_POS];
   assign wr_flag = ctrl_wdata_i[wdt_pkg::IRQ_FLAG_POS];
   assign wr_ps   = {ctrl_wdata_i[wdt_pkg::PS_HI_POS], ctrl_wdata_i[wdt_pkg::PS_LO_MSB:0]};

   assign change_enable_bit = (win_cnt != '0);
   // Both bits in one write open the window, even if reset enable was already set
   assign open_wr = ctrl_wr_i & wr_ce & wr_re;
   // Only a write with change enable clear, inside the window, commits the values
   assign chg_wr  = ctrl_wr_i & ~wr_ce & change_enable_bit;

   // Fuse and reset flag override whatever the register holds
   assign re_eff  = always_on_fuse_i | watchdog_reset_flag_i | reset_enable_bit;
   assign ie_eff  = ~always_on_fuse_i & timeout_irq_enable;

   assign mode = (re_eff && ie_eff) ? wdt_pkg::MODE_BOTH  :
                 re_eff             ? wdt_pkg::MODE_RESET :
                 ie_eff             ? wdt_pkg::MODE_IRQ   : wdt_pkg::MODE_STOP;

   // Oscillator input is sampled on the system clock; one tick per rising edge
   assign tick  = osc_tick_i & ~osc_q;
   assign run   = (mode != wdt_pkg::MODE_STOP);
   assign limit = wdt_pkg::timeout_limit(prescale_select,
                                         wdt_pkg::CNT_W'(BASE_CYCLES));

   // ****************************************************************
   // Expiry actions
   // ****************************************************************
   // Combined mode: a pending interrupt means the first expiry was not serviced
   assign reset_now = expire & ((mode == wdt_pkg::MODE_RESET) |
                                ((mode == wdt_pkg::MODE_BOTH) & timeout_irq_flag));
   assign flag_set  = expire & ((mode == wdt_pkg::MODE_IRQ) |
                                ((mode == wdt_pkg::MODE_BOTH) & ~timeout_irq_flag));
   assign vec_both  = irq_vector_i & (mode == wdt_pkg::MODE_BOTH);
   assign flag_clr  = irq_vector_i | (ctrl_wr_i & wr_flag);

   wdt_counter #(
      .CNT_W    (wdt_pkg::CNT_W)
   ) u_counter (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .tick_i   (tick & run),
      .clear_i  (restart_i | ~run),
      .limit_i  (limit),
      .expire_o (expire)
   );

   // ****************************************************************
   // Next values
   // ****************************************************************
   always_comb begin
      // Setting needs no sequence; clearing only through the window
      if (chg_wr) begin
         next_reset_enable = wr_re;
      end else begin
         next_reset_enable = reset_enable_bit | (ctrl_wr_i & wr_re);
      end
      if (always_on_fuse_i || watchdog_reset_flag_i) begin
         next_reset_enable = 1'b1;
      end

      next_prescale = chg_wr ? wr_ps : prescale_select;

      if (always_on_fuse_i || vec_both) begin
         next_irq_enable = 1'b0;
      end else if (ctrl_wr_i) begin
         next_irq_enable = wr_ie;
      end else begin
         next_irq_enable = timeout_irq_enable;
      end

      // A new expiry outranks a clear in the same cycle
      next_irq_flag = flag_set | (timeout_irq_flag & ~flag_clr);

      if (open_wr) begin
         next_win_cnt = wdt_pkg::WIN_W'(wdt_pkg::CHANGE_WINDOW_CYCLES);
      end else if (chg_wr || !change_enable_bit) begin
         next_win_cnt = '0;
      end else begin
         next_win_cnt = win_cnt - wdt_pkg::WIN_W'(1);
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reset_enable_bit   <= wdt_pkg::RE_RST;
         timeout_irq_enable <= wdt_pkg::IE_RST;
         timeout_irq_flag   <= 1'b0;
         prescale_select    <= wdt_pkg::PS_RST;
         win_cnt            <= '0;
         osc_q              <= 1'b0;
         wdt_reset_o        <= 1'b0;
      end else begin
         reset_enable_bit   <= next_reset_enable;
         timeout_irq_enable <= next_irq_enable;
         timeout_irq_flag   <= next_irq_flag;
         prescale_select    <= next_prescale;
         win_cnt            <= next_win_cnt;
         osc_q              <= osc_tick_i;
         wdt_reset_o        <= reset_now;
      end
   end

   assign timeout_irq_o = timeout_irq_flag & ie_eff;
   assign ctrl_rdata_o  = {timeout_irq_flag, ie_eff, prescale_select[3], change_enable_bit,
                           re_eff, prescale_select[2:0]};

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_window_opens: assert property (@(posedge clk_i) disable iff (rst_i)
      open_wr |=> change_enable_bit)
      else $error("change window did not open");

   a_window_closes: assert property (@(posedge clk_i) disable iff (rst_i)
      open_wr ##1 (!ctrl_wr_i)[*4] |=> !change_enable_bit)
      else $error("change window longer than four cycles");

   a_prescale_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      !chg_wr |=> $stable(prescale_select))
      else $error("prescale changed outside the window");

   a_re_clear_locked: assert property (@(posedge clk_i) disable iff (rst_i)
      reset_enable_bit && !chg_wr |=> reset_enable_bit)
      else $error("reset enable cleared outside the window");

   a_fuse_forces: assert property (@(posedge clk_i) disable iff (rst_i)
      always_on_fuse_i ##1 always_on_fuse_i |->
         ctrl_rdata_o[wdt_pkg::RE_POS] && !ctrl_rdata_o[wdt_pkg::IRQ_EN_POS] && !timeout_irq_o)
      else $error("fuse did not lock the mode bits");

   a_flag_holds_re: assert property (@(posedge clk_i) disable iff (rst_i)
      watchdog_reset_flag_i |=> reset_enable_bit)
      else $error("reset enable not held by reset flag");

   a_reset_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
      expire && (mode == wdt_pkg::MODE_RESET) |=> wdt_reset_o ##1 !wdt_reset_o)
      else $error("reset mode expiry without one-cycle reset");

   a_irq_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
      expire && (mode == wdt_pkg::MODE_IRQ) |=> timeout_irq_flag && !wdt_reset_o)
      else $error("interrupt mode expiry did not set the flag");

   a_both_first: assert property (@(posedge clk_i) disable iff (rst_i)
      expire && (mode == wdt_pkg::MODE_BOTH) && !timeout_irq_flag |=>
         timeout_irq_flag && !wdt_reset_o)
      else $error("combined mode first expiry did not interrupt");

   a_both_vector: assert property (@(posedge clk_i) disable iff (rst_i)
      vec_both && !expire && !ctrl_wr_i |=> !timeout_irq_enable && !timeout_irq_flag)
      else $error("vector did not drop to reset-only mode");

endmodule

// file: watchdog_timer_timed_config_test.sv
// Self-checking testbench of the watchdog timer
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module watchdog_timer_timed_config_test;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       fuse = 1'b0;
   logic       flag = 1'b0;
   wire logic  osc;
   wire logic  rst_req;
   wire logic  vec;
   wire logic  wr;
   wire logic  [7:0] wdata;
   logic [7:0] rdata;
   logic       irq;
   logic       rst_o;
   int         err_total = 0;
   int         num_checks = 0;
   int         n_rst = 0;
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (rst_o === 1'b1) n_rst++;
   wdt_core_model i_wdt_core_model (.clk_i(clk_i), .osc_tick_o(osc), .restart_o(rst_req),
      .irq_vector_o(vec), .ctrl_wr_o(wr), .ctrl_wdata_o(wdata));
   watchdog_timer_timed_config #(.BASE_CYCLES(4)) i_watchdog_timer_timed_config (
      .clk_i(clk_i), .rst_i(rst_i), .osc_tick_i(osc), .always_on_fuse_i(fuse),
      .watchdog_reset_flag_i(flag), .restart_i(rst_req), .irq_vector_i(vec),
      .ctrl_wr_i(wr), .ctrl_wdata_i(wdata), .ctrl_rdata_o(rdata),
      .timeout_irq_o(irq), .wdt_reset_o(rst_o));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Waits for the interrupt (sel 0) or the reset pulse (sel 1)
   task automatic wait_evt(input bit sel, input int lim);
      int n;
      n = 0;
      while (((sel ? rst_o : irq) !== 1'b1) && n < lim) begin
         i_wdt_core_model.step();
         n++;
      end
      if ((sel ? rst_o : irq) !== 1'b1) begin
         err_total++;
         $display("mismatch event expected 1 seen 0");
         stop_test();
      end
   endtask
   initial begin
      int r;
      repeat (4) @(posedge clk_i);
      #1 rst_i = 1'b0;
      `CHK("rdata", 8'h00, rdata)
      i_wdt_core_model.write(8'h27);
      `CHK("rdata", 8'h00, rdata)
      i_wdt_core_model.write(8'h08);
      `CHK("rdata", 8'h08, rdata)
      i_wdt_core_model.write(8'h00);
      `CHK("rdata", 8'h08, rdata)
      i_wdt_core_model.open();
      `CHK("rdata", 8'h18, rdata)
      repeat (2) i_wdt_core_model.step();
      i_wdt_core_model.write(8'h01);
      `CHK("rdata", 8'h01, rdata)
      i_wdt_core_model.write(8'h08);
      i_wdt_core_model.open();
      repeat (3) i_wdt_core_model.step();
      i_wdt_core_model.write(8'h00);
      `CHK("rdata", 8'h09, rdata)
      // ************************************************************
      // Reset mode timing, restart and reserved code
      // ************************************************************
      i_wdt_core_model.restart();
      wait_evt(1'b1, 200);
      `CHK("ticks", 8, i_wdt_core_model.ticks)
      i_wdt_core_model.step();
      `CHK("reset", 1'b0, rst_o)
      r = n_rst;
      repeat (12) i_wdt_core_model.restart();
      `CHK("resets", r, n_rst)
      i_wdt_core_model.open();
      i_wdt_core_model.write(8'h2a);
      i_wdt_core_model.restart();
      wait_evt(1'b1, 20000);
      `CHK("ticks", 2048, i_wdt_core_model.ticks)
      // ************************************************************
      // Interrupt mode and combined mode
      // ************************************************************
      i_wdt_core_model.open();
      i_wdt_core_model.write(8'h40);
      r = n_rst;
      i_wdt_core_model.restart();
      wait_evt(1'b0, 100);
      `CHK("ticks", 4, i_wdt_core_model.ticks)
      `CHK("flag", 1'b1, rdata[7])
      i_wdt_core_model.write(8'hc0);
      `CHK("irq", 1'b0, irq)
      wait_evt(1'b0, 100);
      i_wdt_core_model.vector();
      `CHK("irq", 1'b0, irq)
      `CHK("rdata", 8'h40, rdata)
      `CHK("resets", r, n_rst)
      i_wdt_core_model.write(8'h48);
      i_wdt_core_model.restart();
      wait_evt(1'b0, 100);
      `CHK("resets", r, n_rst)
      i_wdt_core_model.vector();
      `CHK("rdata", 8'h08, rdata)
      i_wdt_core_model.write(8'h48);
      i_wdt_core_model.restart();
      wait_evt(1'b0, 100);
      wait_evt(1'b1, 100);
      `CHK("irq", 1'b1, irq)
      i_wdt_core_model.write(8'h80);
      i_wdt_core_model.open();
      i_wdt_core_model.write(8'h00);
      `CHK("rdata", 8'h00, rdata)
      // ************************************************************
      // Fuse and reset flag overrides
      // ************************************************************
      fuse = 1'b1;
      i_wdt_core_model.write(8'h40);
      `CHK("ie", 1'b0, rdata[6])
      `CHK("re", 1'b1, rdata[3])
      i_wdt_core_model.restart();
      wait_evt(1'b1, 100);
      `CHK("irq", 1'b0, irq)
      i_wdt_core_model.step();
      fuse = 1'b0;
      flag = 1'b1;
      i_wdt_core_model.open();
      i_wdt_core_model.write(8'h00);
      `CHK("re", 1'b1, rdata[3])
      i_wdt_core_model.restart();
      wait_evt(1'b1, 100);
      `CHK("ticks", 4, i_wdt_core_model.ticks)
      flag = 1'b0;
      i_wdt_core_model.open();
      i_wdt_core_model.write(8'h00);
      `CHK("rdata", 8'h00, rdata)
      stop_test();
   end
endmodule

// file: wdt_core_model.sv
// Behavioural processor core and watchdog oscillator facing the watchdog
`timescale 1ns/10ps
module wdt_core_model #(
   parameter int DIV = 8
) (
   input  wire logic       clk_i,
   output logic            osc_tick_o,
   output logic            restart_o,
   output logic            irq_vector_o,
   output logic            ctrl_wr_o,
   output logic      [7:0] ctrl_wdata_o
);
   // ************************************************************
   // Oscillator, sped up to DIV clocks a period so long time-outs fit
   // ************************************************************
   int         phase = 0;
   int         ticks = 0;
   // Requests sit in variables so every output has a live driver behind it
   logic       do_restart = 1'b0;
   logic       do_vector  = 1'b0;
   logic       do_write   = 1'b0;
   logic [7:0] write_word = 8'h00;
   assign restart_o    = do_restart;
   assign irq_vector_o = do_vector;
   assign ctrl_wr_o    = do_write;
   assign ctrl_wdata_o = write_word;
   always @(posedge clk_i) begin
      phase <= (phase + 1) % DIV;
      osc_tick_o <= #1 ((phase + 1) % DIV) < DIV / 2;
      if ((phase + 1) % DIV == 0) begin
         ticks <= ticks + 1;
      end
   end
   // ************************************************************
   // Core actions
   // ************************************************************
   task automatic step();
      @(posedge clk_i);
      #1;
   endtask
   // Restart lands mid-period so it never meets a tick edge
   task automatic restart();
      do step(); while (phase != DIV / 2);
      do_restart = 1'b1;
      ticks = 0;
      step();
      do_restart = 1'b0;
   endtask
   task automatic vector();
      step();
      do_vector = 1'b1;
      step();
      do_vector = 1'b0;
   endtask
   task automatic write(input logic [7:0] d);
      step();
      do_write = 1'b1;
      write_word = d;
      step();
      do_write = 1'b0;
      write_word = ~d;
   endtask
   // Opening write always carries change enable and reset enable
   task automatic open();
      write(8'h18);
   endtask
endmodule

// file: wdt_counter.sv
// Watchdog counter stepped by oscillator ticks, with restart and expiry pulse
`timescale 1ns/10ps
module wdt_counter #(
   parameter int CNT_W = wdt_pkg::CNT_W
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             tick_i,
   input  wire logic             clear_i,
   input  wire logic [CNT_W-1:0] limit_i,
   output logic                  expire_o
);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   wire              at_end;

   // Compare with >= so a shorter prescale taking effect mid-count still expires
   assign at_end = (count >= (limit_i - CNT_W'(1)));

   always_comb begin
      next_count = count;
      if (clear_i) begin
         next_count = '0;
      end else if (tick_i) begin
         next_count = at_end ? '0 : count + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count    <= '0;
         expire_o <= 1'b0;
      end else begin
         count    <= next_count;
         expire_o <= tick_i & ~clear_i & at_end;
      end
   end

   a_restart_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      clear_i |=> (count == '0) && !expire_o)
      else $error("restart did not zero the counter");

   a_expire_isolated: assert property (@(posedge clk_i) disable iff (rst_i)
      expire_o |-> (count == '0) ##1 !expire_o)
      else $error("expiry not followed by counter restart");

endmodule

// file: wdt_pkg.sv
// Shared constants, control-word layout and mode type of the watchdog timer
package wdt_pkg;

   // ****************************************************************
   // Clocks and timing
   // ****************************************************************
   localparam int CLK_FREQ_HZ          = 40_000_000;
   localparam int OSC_FREQ_HZ          = 128_000;
   localparam int CHANGE_WINDOW_CYCLES = 4;
   localparam int TIMEOUT_MIN_US       = 16_000;
   localparam int TIMEOUT_MAX_US       = 8_000_000;
   // Shortest time-out expressed in watchdog oscillator cycles
   localparam int BASE_OSC_CYCLES      = TIMEOUT_MIN_US / 1000 * (OSC_FREQ_HZ / 1000);
   localparam int CNT_W                = 21;
   localparam int WIN_W                = 3;

   // ****************************************************************
   // Control word layout
   // ****************************************************************
   localparam int CTRL_W       = 8;
   localparam int IRQ_FLAG_POS = 7;
   localparam int IRQ_EN_POS   = 6;
   localparam int PS_HI_POS    = 5;
   localparam int CE_POS       = 4;
   localparam int RE_POS       = 3;
   localparam int PS_LO_MSB    = 2;

   // ****************************************************************
   // Reset values and codes
   // ****************************************************************
   localparam logic [3:0] PS_RST      = 4'h0;
   localparam logic [3:0] PS_MAX_CODE = 4'h9;
   localparam logic       RE_RST      = 1'b0;
   localparam logic       IE_RST      = 1'b0;

   typedef enum logic [1:0] {MODE_STOP, MODE_IRQ, MODE_RESET, MODE_BOTH} mode_t;

   // Time-out length in oscillator cycles; reserved codes behave as the longest one
   function automatic logic [CNT_W-1:0] timeout_limit(input logic [3:0]       code,
                                                      input logic [CNT_W-1:0] base);
      logic [3:0] c;
      c = (code > PS_MAX_CODE) ? PS_MAX_CODE : code;
      return base << c;
   endfunction

endpackage
